/* hw/aps_pkg.sv */
`default_nettype none
package aps_pkg;
	// ----------------------------------------------------------------
	// Widths and depths
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 24;
	localparam int unsigned HALF_W = 12;
	localparam int unsigned MAP_W = 6;
	localparam int unsigned NUM_OUT = 24;
	localparam int unsigned NUM_LANES = 2;
	localparam int unsigned NUM_PARAMS = 5;
	localparam int unsigned FIFO_DEPTH = 8;
	localparam int unsigned OD_W = 3;
	localparam int unsigned OD_TAPS = 7;
	localparam int unsigned SD_W = 5;
	localparam int unsigned PTR_W = 5;
	localparam int unsigned APB_AW = 8;
	localparam int unsigned APB_DW = 32;
	localparam int unsigned FCNT_W = 4;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [APB_AW-1:0] REG_START_ADDR = 8'h00;
	localparam logic [APB_AW-1:0] REG_STEP = 8'h04;
	localparam logic [APB_AW-1:0] REG_BLOCK_SIZE = 8'h08;
	localparam logic [APB_AW-1:0] REG_NUM_BLOCKS = 8'h0C;
	localparam logic [APB_AW-1:0] REG_BLOCK_STEP = 8'h10;
	localparam logic [APB_AW-1:0] REG_MODE = 8'h14;
	localparam logic [APB_AW-1:0] REG_START_DELAY = 8'h18;
	localparam logic [APB_AW-1:0] REG_CTRL = 8'h1C;
	localparam logic [APB_AW-1:0] REG_STATUS = 8'h20;
	localparam logic [APB_AW-1:0] REG_XPT_PTR = 8'h24;
	localparam logic [APB_AW-1:0] REG_XPT_DATA = 8'h28;

	// Parameter slots inside the parameter array.
	localparam int unsigned PAR_START = 0;
	localparam int unsigned PAR_STEP = 1;
	localparam int unsigned PAR_BSIZE = 2;
	localparam int unsigned PAR_NBLK = 3;
	localparam int unsigned PAR_BSTEP = 4;

	// ----------------------------------------------------------------
	// Field positions and values
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_START_BIT = 0;
	localparam int unsigned AUTO_INC_BIT = 6;
	localparam int unsigned ST_BUSY_BIT = 0;
	localparam int unsigned ST_DONE_LSB = 1;
	localparam int unsigned ST_FCNT_LSB = 4;
	localparam logic [1:0] MODE_ONESHOT = 2'h0;
	localparam logic [1:0] MODE_RESTART = 2'h1;
	localparam int unsigned MODE_CONT_BIT = 1;
	localparam logic [ADDR_W-1:0] MASK_FULL = 24'hFFFFFF;
	localparam logic [ADDR_W-1:0] MASK_HALF = 24'h000FFF;
	localparam logic [ADDR_W-1:0] ONE_W = 24'h000001;
	localparam logic [ADDR_W-1:0] ZERO_W = 24'h000000;
	localparam logic [SD_W-1:0] SD_ONE = 5'h01;
	localparam logic [SD_W-1:0] SD_ZERO = 5'h00;
	localparam logic [PTR_W-1:0] PTR_ONE = 5'h01;
	localparam logic [PTR_W-1:0] PTR_RESET = 5'h00;
	localparam logic [APB_DW-1:0] DATA_ZERO = 32'h00000000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [OD_W-1:0] od;
		logic ds;
		logic [1:0] m;
	} aps_mode_type;

	typedef struct packed {
		logic sde;
		logic [SD_W-1:0] sd;
	} aps_sdly_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [ADDR_W-1:0] bstart;
		logic [ADDR_W-1:0] icnt;
		logic [ADDR_W-1:0] bcnt;
		logic done;
	} aps_lane_type;

	typedef logic [NUM_OUT-1:0][MAP_W-1:0] aps_map_type;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'h0,
		SEQ_WAIT = 2'h1,
		SEQ_RUN = 2'h3
	} aps_state_type;

	localparam aps_mode_type MODE_RESET = 6'h00;
	localparam aps_sdly_type SDLY_RESET = 6'h00;

	function automatic aps_map_type aps_identity_map();
		aps_map_type m;
		for (int i = 0; i < NUM_OUT; i++)
		begin
			m[i] = MAP_W'(i);
		end
		return m;
	endfunction
endpackage
`default_nettype wire

/* hw/aps_fifo.sv */
`default_nettype none
module aps_fifo #(
	parameter int unsigned WIDTH = 24,
	parameter int unsigned DEPTH = 8
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH+1)-1:0] level
);
	localparam int unsigned PW = $clog2(DEPTH);
	localparam int unsigned CW = $clog2(DEPTH+1);
	localparam logic [PW-1:0] LAST = PW'(DEPTH-1);
	localparam logic [CW-1:0] FULLC = CW'(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic push, pop;

	assign in_ready = (cnt_r != FULLC);
	assign out_valid = (cnt_r != '0);
	assign out_data = mem_r[rptr_r];
	assign level = cnt_r;

	always_comb
	begin
		push = in_valid & in_ready;
		pop = out_valid & out_ready;
		wptr_nxt = push ? ((wptr_r == LAST) ? '0 : wptr_r + 1'b1) : wptr_r;
		rptr_nxt = pop ? ((rptr_r == LAST) ? '0 : rptr_r + 1'b1) : rptr_r;
		cnt_nxt = cnt_r;
		if (push && !pop)
		begin
			cnt_nxt = cnt_r + 1'b1;
		end
		else if (pop && !push)
		begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end

	// Storage is not reset; only the pointers and the count define what is valid.
	always_ff @(posedge pclk)
	begin
		if (ce && push)
		begin
			mem_r[wptr_r] <= in_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wptr_r <= '0;
			rptr_r <= '0;
			cnt_r <= '0;
		end
		else if (ce)
		begin
			wptr_r <= wptr_nxt;
			rptr_r <= rptr_nxt;
			cnt_r <= cnt_nxt;
		end
	end
endmodule
`default_nettype wire

/* hw/aps_xpt.sv */
`default_nettype none
module aps_xpt (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic en,
	// Count in
	input wire logic in_valid,
	input wire logic [aps_pkg::ADDR_W-1:0] in_word,
	input wire aps_pkg::aps_map_type map,
	// Permuted word out
	output logic out_valid,
	output logic [aps_pkg::ADDR_W-1:0] out_word
);
	import aps_pkg::*;

	logic [ADDR_W-1:0] word_nxt, word_r;
	logic valid_r;

	assign out_valid = valid_r;
	assign out_word = word_r;

	always_comb
	begin
		word_nxt = '0;
		for (int i = 0; i < NUM_OUT; i++)
		begin
			if (map[i] < MAP_W'(NUM_OUT))
			begin
				word_nxt[i] = in_word[map[i][PTR_W-1:0]];
			end
			else
			begin
				word_nxt[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			word_r <= '0;
			valid_r <= 1'b0;
		end
		else if (ce && en)
		begin
			word_r <= word_nxt;
			valid_r <= in_valid;
		end
	end
endmodule
`default_nettype wire

/* hw/aps_top.sv */
// Summary of operation
// - Block begins at start address; each next address adds the step size.
// - Next block begins at previous block start plus block step size.
// - Block holds block-size addresses; sequence holds number-of-blocks blocks.
// - Each output bit takes the count bit chosen by its mapping register.
// - Reset loads the mapping registers with the identity mapping.
// - Mapping writes go to a shadow copy, made active at start/restart and at each continuous-mode repeat.
// - Data writes with auto-increment set advance the mapping pointer.
// - Dual mode runs two independent 12-bit sequences, one per output half.
// - A programmable delay stands between upper and lower output halves.
// - A mapping source index above 23 drives its output bit to zero.
// - Lower twelve bits lag the upper twelve by 0 to 7 clocks.
// - With start delay enabled, all starts and restarts wait 1 to 31 clocks.
// - Mode selects one-shot, one-shot with restart, or continuous operation.
//
// Implementation choices: register access over APB and the register addresses.
`default_nettype none
module aps_top (
	// Clock, reset and enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [aps_pkg::APB_AW-1:0] paddr,
	input wire logic [aps_pkg::APB_DW-1:0] pwdata,
	output logic [aps_pkg::APB_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Sequence control
	input wire logic start_in,
	output logic busy,
	// Address output
	output logic [aps_pkg::ADDR_W-1:0] address_out_bus,
	output logic addr_valid,
	input wire logic out_ready
);
	import aps_pkg::*;

	// Held as a constant so that the reset branches load constants only.
	localparam aps_map_type MAP_IDENT = aps_identity_map();

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [ADDR_W-1:0] par_r [NUM_PARAMS];
	logic [ADDR_W-1:0] par_nxt [NUM_PARAMS];
	aps_mode_type mode_r, mode_nxt;
	aps_sdly_type sdly_r, sdly_nxt;
	logic [PTR_W-1:0] xptr_r, xptr_nxt;
	aps_map_type map_r, map_nxt, amap_r, amap_nxt;
	logic [APB_DW-1:0] prdata_r, prdata_nxt;
	logic pready_r, pslverr_r, pslverr_nxt;
	logic start_sw;

	aps_state_type state_r, state_nxt;
	logic [SD_W-1:0] dly_r, dly_nxt;
	aps_lane_type lane_r [NUM_LANES];
	aps_lane_type lane_nxt [NUM_LANES];
	logic busy_r;
	logic emit, adv_ok;
	logic [ADDR_W-1:0] raw_word;

	logic xv, fifo_in_ready, fifo_out_valid, pop;
	logic [ADDR_W-1:0] xword, fifo_data;
	logic [FCNT_W-1:0] fifo_level;

	logic [HALF_W-1:0] hist_r [OD_TAPS];
	logic [HALF_W-1:0] hist_nxt [OD_TAPS];
	logic [HALF_W-1:0] lo_in, out_lo_r, out_lo_nxt, out_hi_r, out_hi_nxt;
	logic valid_r;

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign busy = busy_r;
	assign address_out_bus = {out_hi_r, out_lo_r};
	assign addr_valid = valid_r;

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	function automatic logic addr_ok(input logic [APB_AW-1:0] a);
		if (a == REG_START_ADDR || a == REG_STEP || a == REG_BLOCK_SIZE)
			return 1'b1;
		else if (a == REG_NUM_BLOCKS || a == REG_BLOCK_STEP || a == REG_MODE)
			return 1'b1;
		else if (a == REG_START_DELAY || a == REG_CTRL || a == REG_STATUS)
			return 1'b1;
		else if (a == REG_XPT_PTR || a == REG_XPT_DATA)
			return 1'b1;
		else
			return 1'b0;
	endfunction

	// Parameter of one lane: in dual mode lane 1 takes the upper half of each register.
	function automatic logic [ADDR_W-1:0] lane_par(input logic [ADDR_W-1:0] v, input int l, input logic ds);
		if (!ds)
			return v;
		else if (l == 0)
			return v & MASK_HALF;
		else
			return {{HALF_W{1'b0}}, v[ADDR_W-1:HALF_W]};
	endfunction

	// A programmed count of zero is taken as one, so the counter never wraps.
	function automatic logic [ADDR_W-1:0] count_load(input logic [ADDR_W-1:0] v);
		return (v == ZERO_W) ? ZERO_W : v - ONE_W;
	endfunction

	// ----------------------------------------------------------------
	// APB register file
	// ----------------------------------------------------------------
	always_comb
	begin
		logic acc_wr;
		logic [APB_DW-1:0] rd;
		acc_wr = psel & penable & pready_r & pwrite;
		rd = DATA_ZERO;
		for (int p = 0; p < NUM_PARAMS; p++)
		begin
			par_nxt[p] = par_r[p];
		end
		mode_nxt = mode_r;
		sdly_nxt = sdly_r;
		xptr_nxt = xptr_r;
		map_nxt = map_r;
		start_sw = 1'b0;
		prdata_nxt = prdata_r;
		pslverr_nxt = pslverr_r;
		if (psel && !penable)
		begin
			if (paddr == REG_START_ADDR || paddr == REG_STEP || paddr == REG_BLOCK_SIZE
				|| paddr == REG_NUM_BLOCKS || paddr == REG_BLOCK_STEP)
				rd = APB_DW'(par_r[paddr[4:2]]);
			else if (paddr == REG_MODE)
				rd = APB_DW'(mode_r);
			else if (paddr == REG_START_DELAY)
				rd = APB_DW'(sdly_r);
			else if (paddr == REG_STATUS)
			begin
				rd[ST_BUSY_BIT] = (state_r != SEQ_IDLE);
				rd[ST_DONE_LSB] = lane_r[0].done;
				rd[ST_DONE_LSB+1] = lane_r[1].done;
				rd[ST_FCNT_LSB +: FCNT_W] = fifo_level;
			end
			else if (paddr == REG_XPT_PTR)
				rd = APB_DW'(xptr_r);
			else if (paddr == REG_XPT_DATA && xptr_r < PTR_W'(NUM_OUT))
				rd = APB_DW'(map_r[xptr_r]);
			prdata_nxt = rd;
			pslverr_nxt = ~addr_ok(paddr);
		end
		if (acc_wr)
		begin
			if (paddr == REG_START_ADDR || paddr == REG_STEP || paddr == REG_BLOCK_SIZE
				|| paddr == REG_NUM_BLOCKS || paddr == REG_BLOCK_STEP)
				par_nxt[paddr[4:2]] = pwdata[ADDR_W-1:0];
			else if (paddr == REG_MODE)
				mode_nxt = pwdata[$bits(aps_mode_type)-1:0];
			else if (paddr == REG_START_DELAY)
				sdly_nxt = pwdata[$bits(aps_sdly_type)-1:0];
			else if (paddr == REG_CTRL)
				start_sw = pwdata[CTRL_START_BIT];
			else if (paddr == REG_XPT_PTR)
				xptr_nxt = pwdata[PTR_W-1:0];
			else if (paddr == REG_XPT_DATA)
			begin
				if (xptr_r < PTR_W'(NUM_OUT))
					map_nxt[xptr_r] = pwdata[MAP_W-1:0];
				if (pwdata[AUTO_INC_BIT])
					xptr_nxt = xptr_r + PTR_ONE;
			end
		end
	end

	// Parameter registers are reset too, so no unknown reaches the counters.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int p = 0; p < NUM_PARAMS; p++)
			begin
				par_r[p] <= ZERO_W;
			end
			mode_r <= MODE_RESET;
			sdly_r <= SDLY_RESET;
			xptr_r <= PTR_RESET;
			map_r <= MAP_IDENT;
			prdata_r <= DATA_ZERO;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
		else if (ce)
		begin
			for (int p = 0; p < NUM_PARAMS; p++)
			begin
				par_r[p] <= par_nxt[p];
			end
			mode_r <= mode_nxt;
			sdly_r <= sdly_nxt;
			xptr_r <= xptr_nxt;
			map_r <= map_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= 1'b1;
			pslverr_r <= pslverr_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Sequence generator
	// ----------------------------------------------------------------
	assign adv_ok = fifo_in_ready | ~xv;
	assign emit = (state_r == SEQ_RUN) & adv_ok;
	assign raw_word = mode_r.ds ? {lane_r[1].addr[HALF_W-1:0], lane_r[0].addr[HALF_W-1:0]}
		: lane_r[0].addr;

	always_comb
	begin
		logic go_req, launch, all_last;
		logic [ADDR_W-1:0] msk, nb;
		go_req = 1'b0;
		launch = 1'b0;
		all_last = 1'b1;
		msk = mode_r.ds ? MASK_HALF : MASK_FULL;
		nb = ZERO_W;
		state_nxt = state_r;
		dly_nxt = dly_r;
		amap_nxt = amap_r;
		for (int l = 0; l < NUM_LANES; l++)
		begin
			lane_nxt[l] = lane_r[l];
			if ((l == 0 || mode_r.ds) && !lane_r[l].done
				&& (lane_r[l].icnt != ZERO_W || lane_r[l].bcnt != ZERO_W))
				all_last = 1'b0;
		end
		case (state_r)
			SEQ_IDLE:
			begin
				go_req = start_sw | start_in;
			end
			SEQ_WAIT:
			begin
				if (dly_r == SD_ONE)
					launch = 1'b1;
				else
					dly_nxt = dly_r - SD_ONE;
			end
			SEQ_RUN:
			begin
				if (start_sw || start_in)
					go_req = 1'b1;
				else if (emit && all_last)
				begin
					if (mode_r.m[MODE_CONT_BIT])
						launch = 1'b1;
					else if (mode_r.m == MODE_RESTART)
						go_req = 1'b1;
					else
						state_nxt = SEQ_IDLE;
				end
				else if (emit)
				begin
					for (int l = 0; l < NUM_LANES; l++)
					begin
						nb = (lane_r[l].bstart + lane_par(par_r[PAR_BSTEP], l, mode_r.ds)) & msk;
						if (lane_r[l].done)
							lane_nxt[l] = lane_r[l];
						else if (lane_r[l].icnt != ZERO_W)
						begin
							lane_nxt[l].addr = (lane_r[l].addr + lane_par(par_r[PAR_STEP], l, mode_r.ds)) & msk;
							lane_nxt[l].icnt = lane_r[l].icnt - ONE_W;
						end
						else if (lane_r[l].bcnt != ZERO_W)
						begin
							lane_nxt[l].addr = nb;
							lane_nxt[l].bstart = nb;
							lane_nxt[l].icnt = count_load(lane_par(par_r[PAR_BSIZE], l, mode_r.ds));
							lane_nxt[l].bcnt = lane_r[l].bcnt - ONE_W;
						end
						else
							lane_nxt[l].done = 1'b1;
					end
				end
			end
			default:
			begin
				state_nxt = SEQ_IDLE;
			end
		endcase
		if (go_req)
		begin
			if (sdly_r.sde && sdly_r.sd != SD_ZERO)
			begin
				state_nxt = SEQ_WAIT;
				dly_nxt = sdly_r.sd;
			end
			else
				launch = 1'b1;
		end
		if (launch)
		begin
			state_nxt = SEQ_RUN;
			amap_nxt = map_r;
			for (int l = 0; l < NUM_LANES; l++)
			begin
				lane_nxt[l].addr = lane_par(par_r[PAR_START], l, mode_r.ds) & msk;
				lane_nxt[l].bstart = lane_par(par_r[PAR_START], l, mode_r.ds) & msk;
				lane_nxt[l].icnt = count_load(lane_par(par_r[PAR_BSIZE], l, mode_r.ds));
				lane_nxt[l].bcnt = count_load(lane_par(par_r[PAR_NBLK], l, mode_r.ds));
				lane_nxt[l].done = (l != 0) && !mode_r.ds;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= SEQ_IDLE;
			dly_r <= SD_ZERO;
			amap_r <= MAP_IDENT;
			busy_r <= 1'b0;
			for (int l = 0; l < NUM_LANES; l++)
			begin
				lane_r[l] <= '0;
			end
		end
		else if (ce)
		begin
			state_r <= state_nxt;
			dly_r <= dly_nxt;
			amap_r <= amap_nxt;
			busy_r <= (state_nxt != SEQ_IDLE);
			for (int l = 0; l < NUM_LANES; l++)
			begin
				lane_r[l] <= lane_nxt[l];
			end
		end
	end

	// ----------------------------------------------------------------
	// Crosspoint switch and output buffer
	// ----------------------------------------------------------------
	aps_xpt u_xpt (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.en(adv_ok),
		.in_valid(emit),
		.in_word(raw_word),
		.map(amap_r),
		.out_valid(xv),
		.out_word(xword)
	);

	// A full buffer stalls the switch stage and so the generator itself.
	aps_fifo #(
		.WIDTH(ADDR_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.in_valid(xv),
		.in_ready(fifo_in_ready),
		.in_data(xword),
		.out_valid(fifo_out_valid),
		.out_ready(out_ready),
		.out_data(fifo_data),
		.level(fifo_level)
	);

	// ----------------------------------------------------------------
	// Output half delay
	// ----------------------------------------------------------------
	// The lower half follows the upper one clock for clock; a word that is
	// not refilled keeps its last value, so a stalled output repeats it.
	assign pop = fifo_out_valid & out_ready;

	always_comb
	begin
		lo_in = pop ? fifo_data[HALF_W-1:0] : hist_r[0];
		out_hi_nxt = pop ? fifo_data[ADDR_W-1:HALF_W] : out_hi_r;
		hist_nxt[0] = lo_in;
		for (int k = 1; k < OD_TAPS; k++)
		begin
			hist_nxt[k] = hist_r[k-1];
		end
		if (mode_r.od == '0)
			out_lo_nxt = lo_in;
		else
			out_lo_nxt = hist_r[mode_r.od - 1'b1];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int k = 0; k < OD_TAPS; k++)
			begin
				hist_r[k] <= '0;
			end
			out_lo_r <= '0;
			out_hi_r <= '0;
			valid_r <= 1'b0;
		end
		else if (ce)
		begin
			hist_r <= hist_nxt;
			out_lo_r <= out_lo_nxt;
			out_hi_r <= out_hi_nxt;
			valid_r <= pop;
		end
	end
endmodule
`default_nettype wire

/* verification/aps_mem_model.sv */
`default_nettype none
module aps_mem_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pace: 0 always ready, 1 every other cycle, 2 stalled
	input wire logic [1:0] pace,
	output logic out_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic tog;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tog <= 1'b0;
		else
			tog <= !tog;
	end
	// A slow bank takes a word every other cycle, so the buffer in front of it backs up.
	assign out_ready = (pace == 2'h0) || (pace == 2'h1 && tog);
endmodule
`default_nettype wire

/* verification/aps_top_chk.sv */
`default_nettype none
module aps_top_chk (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [aps_pkg::APB_AW-1:0] paddr,
	input wire logic [aps_pkg::APB_DW-1:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// Sequence
	input wire logic start_in,
	input wire logic busy,
	input wire logic addr_valid,
	input wire logic out_ready
);
	import aps_pkg::*;
	logic [5:0] sdly_r;
	logic [5:0] sdly_nxt;
	logic wr_acc;
	logic go;
	logic no_dly;
	assign wr_acc = psel && penable && pwrite && pready;
	assign go = start_in || (wr_acc && paddr == REG_CTRL && pwdata[CTRL_START_BIT]);
	assign no_dly = !(sdly_r[5] && sdly_r[4:0] != 5'h00);
	always_comb
	begin
		sdly_nxt = (wr_acc && paddr == REG_START_DELAY) ? pwdata[5:0] : sdly_r;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sdly_r <= 6'h00;
		else
			sdly_r <= sdly_nxt;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_bad_addr: assert property (psel && !penable && paddr > REG_XPT_DATA |=> pslverr)
		else $error("unmapped address not flagged");
	chk_good_addr: assert property (psel && !penable && paddr <= REG_XPT_DATA && paddr[1:0] == 2'h0 |=> !pslverr)
		else $error("mapped address flagged");
	chk_ready_holds: assert property (pready |=> pready)
		else $error("ready dropped");
	chk_start_busy: assert property (go && !busy |=> busy)
		else $error("start did not raise busy");
	chk_idle_holds: assert property (!busy && !go |=> !busy)
		else $error("busy without a start");
	chk_first_word: assert property (go && !busy && out_ready && no_dly |-> ##[2:12] addr_valid)
		else $error("no word after start");
	chk_delayed_start: assert property (go && !busy && sdly_r == 6'h24 |=> (!addr_valid)[*6] ##[0:8] addr_valid)
		else $error("start delay not kept");
	chk_pop_ready: assert property (addr_valid |-> $past(out_ready))
		else $error("word without ready");
endmodule
`default_nettype wire

/* verification/aps_top_tb.sv */
`default_nettype none
module aps_top_tb;
	import aps_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, start_in, pready, pslverr, busy, addr_valid, out_ready;
	logic [APB_AW-1:0] paddr;
	logic [APB_DW-1:0] pwdata, prdata;
	logic [ADDR_W-1:0] address_out_bus;
	logic [1:0] pace;
	logic [7:0] cur, hist = 8'h00;
	logic [2:0] od_cfg;
	logic [11:0] upq[$], loq[$];
	logic [23:0] eq[$];
	int fail_count, compares, cyc;
	always #20 pclk = !pclk;
	aps_top i_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .start_in(start_in),
		.busy(busy), .address_out_bus(address_out_bus), .addr_valid(addr_valid), .out_ready(out_ready));
	aps_mem_model i_mem (.pclk(pclk), .presetn(presetn), .pace(pace), .out_ready(out_ready));
	// --------------------------------------------------------------
	// Collector: the lower half is taken od cycles after its word
	// --------------------------------------------------------------
	always @(posedge pclk)
	begin
		cur = {hist[6:0], addr_valid};
		if (addr_valid === 1'b1)
			upq.push_back(address_out_bus[23:12]);
		if (cur[od_cfg] === 1'b1)
			loq.push_back(address_out_bus[11:0]);
		hist <= cur;
		cyc++;
		if (cyc == 6000)
		begin
			fail_count++;
			conclude();
		end
	end
	task automatic conclude;
		$display("compares %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic experr);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h00000000, r, e);
		chk(r, exp);
		chk({31'h00000000, e}, {31'h00000000, experr});
	endtask
	task automatic cfg(input logic [23:0] s, st, bs, nb, bst, input logic [5:0] m);
		wr(REG_START_ADDR, {8'h00, s});
		wr(REG_STEP, {8'h00, st});
		wr(REG_BLOCK_SIZE, {8'h00, bs});
		wr(REG_NUM_BLOCKS, {8'h00, nb});
		wr(REG_BLOCK_STEP, {8'h00, bst});
		wr(REG_MODE, {26'h0000000, m});
	endtask
	task automatic go_pin;
		start_in <= 1'b1;
		@(posedge pclk);
		start_in <= 1'b0;
	endtask
	// A slow bank still drains up to nine words after busy falls.
	task automatic settle;
		@(posedge pclk);
		while (busy !== 1'b0)
			@(posedge pclk);
		repeat (40) @(posedge pclk);
	endtask
	task automatic cmp_words;
		chk(32'(upq.size()), 32'(eq.size()));
		chk(32'(loq.size()), 32'(eq.size()));
		foreach (eq[i])
			if (i < upq.size() && i < loq.size())
				chk({8'h00, upq[i], loq[i]}, {8'h00, eq[i]});
		upq.delete();
		loq.delete();
		eq.delete();
	endtask
	task automatic t_regs;
		rd(REG_MODE, 32'h00000000, 1'b0);
		rd(REG_START_DELAY, 32'h00000000, 1'b0);
		for (int p = 0; p < 24; p += 7)
		begin
			wr(REG_XPT_PTR, 32'(p));
			rd(REG_XPT_DATA, 32'(p), 1'b0);
		end
		rd(8'h3C, 32'h00000000, 1'b1);
		$display("register test done");
	endtask
	task automatic t_image;
		logic [31:0] r;
		logic e;
		cfg(24'h000023, 24'h000001, 24'h000008, 24'h000008, 24'h000010, 6'h00);
		pace <= 2'h2;
		@(posedge pclk);
		go_pin();
		repeat (30) @(posedge pclk);
		apb(1'b0, REG_STATUS, 32'h00000000, r, e);
		chk(r & 32'h000000F1, 32'h00000081);
		pace <= 2'h1;
		for (int b = 0; b < 8; b++)
			for (int i = 0; i < 8; i++)
				eq.push_back(24'h000023 + 24'(16 * b + i));
		settle();
		pace <= 2'h0;
		cmp_words();
		repeat (20) @(posedge pclk);
		chk({31'h00000000, busy} | 32'(upq.size()), 32'h00000000);
		$display("image test done");
	endtask
	task automatic t_map;
		logic [2:0] k;
		cfg(24'h000008, 24'h000001, 24'h000008, 24'h000001, 24'h000000, 6'h00);
		wr(REG_XPT_PTR, 32'h00000000);
		wr(REG_XPT_DATA, 32'h00000041);
		wr(REG_XPT_DATA, 32'h00000042);
		wr(REG_XPT_DATA, 32'h00000040);
		wr(REG_XPT_DATA, 32'h0000007F);
		rd(REG_XPT_PTR, 32'h00000004, 1'b0);
		go_pin();
		wr(REG_XPT_PTR, 32'h00000000);
		wr(REG_XPT_DATA, 32'h00000000);
		for (int i = 0; i < 8; i++)
		begin
			k = 3'(i);
			eq.push_back({21'h000000, k[0], k[2], k[1]});
		end
		settle();
		cmp_words();
		wr(REG_CTRL, 32'h00000001);
		for (int i = 0; i < 8; i++)
		begin
			k = 3'(i);
			eq.push_back({21'h000000, k[0], k[2], k[0]});
		end
		settle();
		cmp_words();
		wr(REG_XPT_PTR, 32'h00000000);
		for (int p = 0; p < 4; p++)
			wr(REG_XPT_DATA, 32'h00000040 + 32'(p));
		$display("mapping test done");
	endtask
	task automatic t_dual;
		od_cfg = 3'h3;
		cfg(24'h100010, 24'h002001, 24'h004004, 24'h001001, 24'h000000, 6'h1C);
		go_pin();
		for (int i = 0; i < 4; i++)
			eq.push_back({12'h100 + 12'(2 * i), 12'h010 + 12'(i)});
		settle();
		cmp_words();
		wr(REG_MODE, 32'h00000000);
		od_cfg = 3'h0;
		$display("dual test done");
	endtask
	task automatic measure(output int n);
		go_pin();
		n = 1;
		while (addr_valid !== 1'b1 && n < 100)
		begin
			@(posedge pclk);
			n++;
		end
		settle();
	endtask
	task automatic t_delay;
		int n0, n1;
		cfg(24'h000000, 24'h000001, 24'h000002, 24'h000001, 24'h000000, 6'h00);
		measure(n0);
		wr(REG_START_DELAY, 32'h00000024);
		measure(n1);
		chk(32'(n1 - n0), 32'h00000004);
		wr(REG_START_DELAY, 32'h00000000);
		for (int m = 0; m < 4; m++)
		begin
			wr(REG_MODE, 32'(m));
			go_pin();
			repeat (40) @(posedge pclk);
			chk({31'h00000000, busy}, 32'(m != 0));
			wr(REG_MODE, 32'h00000000);
			settle();
		end
		upq.delete();
		loq.delete();
		$display("delay and mode test done");
	endtask
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		start_in = 1'b0;
		pace = 2'h0;
		od_cfg = 3'h0;
		fail_count = 0;
		compares = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		t_regs();
		t_image();
		t_map();
		t_dual();
		t_delay();
		conclude();
	end
endmodule
bind aps_top aps_top_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .start_in(start_in), .busy(busy),
	.addr_valid(addr_valid), .out_ready(out_ready));
`default_nettype wire
